//--- logic/lce_pkg.sv
// constants, register map and step encoding for the line/char edit sequencer
// assumes one 25 MHz system clock; memory and keyboard logic live outside
`default_nettype none

package lce_pkg;

	localparam int          ROW_W       = 5;
	localparam int          COL_W       = 7;
	localparam int          CHAR_W      = 8;
	localparam logic [4:0]  LAST_ROW    = 5'h1A;
	localparam logic [6:0]  LAST_COL    = 7'h49;

	// memory cycle phases t0.1 .. t0.6, one system clock each
	localparam logic [2:0]  PH1         = 3'h0;
	localparam logic [2:0]  PH2         = 3'h1;
	localparam logic [2:0]  PH3         = 3'h2;
	localparam logic [2:0]  PH4         = 3'h3;
	localparam logic [2:0]  PH6         = 3'h5;

	localparam logic [7:0]  BLANK_CHAR  = 8'h00;
	localparam logic [7:0]  CR_CHAR     = 8'h0D;
	localparam int          FG_BIT      = 7;

	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_CURSOR  = 8'h04;
	localparam logic [7:0]  OFS_STATUS  = 8'h08;
	localparam int          CTRL_DL_BIT = 0;
	localparam int          CUR_COL_LSB = 0;
	localparam int          CUR_ROW_LSB = 8;
	localparam int          ST_BUSY     = 0;
	localparam int          ST_LAST     = 1;
	localparam int          ST_SKIP     = 2;
	localparam int          ST_INS      = 3;
	localparam int          ST_STEP_LSB = 4;

	typedef enum logic [3:0] {
		STP_IDLE, STP_S1, STP_S2, STP_S3, STP_S4, STP_S5, STP_S6, STP_XFER
	} lce_step_type;

endpackage : lce_pkg

`default_nettype wire

//--- logic/lce_sequencer.sv
// delete-line and insert-character step sequencer over the character memory
// assumes memory answers a read-restore with data valid the cycle after o_rr_cmd
`default_nettype none

// Notes on behaviour
// - delete line starts from keyboard pin or host write; same steps either way
// - delete line removes cursor row, rolls rows below it up, blanks bottom row
// - delete step one clears column on t0.2, no line repeat load
// - step one leads to step two and resets the last-line flag
// - step two saves complemented cursor row and column in coincidence counters
// - step three: last-line flag sets on t0.2 only at row 26
// - step three increments the row on t0.3
// - step three issues read-restore on t0.6, result lands in A
// - step four decrements row on t0.3 and copies A into B on t0.6
// - step four writes A on t0.6 while last-line flag is reset
// - step four writes blank on t0.6 once last-line flag is set
// - at column 73 row 26 step six stops and restore flop arms for t0.1
// - restore flop clears counters on t0.2, reloads saved cursor on t0.4
// - step six re-enters step three, column steps on t0.3, carry bumps row
// - steps three to six loop until last position done, then terminate
// - insert places typed char, shifts foreground right to background or end
// - insert step one sets refresh-skip flop for the routine
// - insert step two saves cursor and reads cursor cell on t0.6
// - background at cursor: no insert, restore flop t0.1, cursor back t0.4
// - foreground and not carriage return: write typed char on t0.6
// - insert at column 73 row 26 skips step five and restores cursor
// - insert step five: column up t0.3, A to B and next read on t0.6
// - insert step six: foreground loops four to six writing B
// - insert step six background: no write, restore saved cursor
module lce_sequencer (
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset,
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic              i_key_del_line,
	input  wire logic              i_key_ins_char,
	input  wire logic [7:0]        i_key_char,
	input  wire logic [7:0]        i_mem_rdata,
	output logic [31:0]            o_rdata,
	output logic [4:0]             o_mem_row,
	output logic [6:0]             o_mem_col,
	output logic                   o_rr_cmd,
	output logic                   o_cw_cmd,
	output logic [7:0]             o_cw_data,
	output logic                   o_skip_refresh,
	output logic                   o_busy
);

	lce_pkg::lce_step_type step_r;
	lce_pkg::lce_step_type step_nxt;
	logic [2:0]  phase_r;
	logic [4:0]  row_r;
	logic [4:0]  row_nxt;
	logic [6:0]  col_r;
	logic [6:0]  col_nxt;
	logic [4:0]  crow_r;
	logic [6:0]  ccol_r;
	logic [7:0]  a_r;
	logic [7:0]  b_r;
	logic [7:0]  char_r;
	logic [7:0]  chr_s1_r;
	logic [7:0]  chr_s2_r;
	logic        dl_s1_r;
	logic        dl_s2_r;
	logic        dl_s3_r;
	logic        ic_s1_r;
	logic        ic_s2_r;
	logic        ic_s3_r;
	logic        is_ic_r;
	logic        last_r;
	logic        xfer_r;
	logic        end_r;
	logic        skip_r;
	logic        rr_r;
	logic        rr_d_r;
	logic        cw_r;
	logic [7:0]  cwd_r;
	logic [7:0]  cwd_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// phase ticks and step decode
	wire t1 = (phase_r == lce_pkg::PH1);
	wire t2 = (phase_r == lce_pkg::PH2);
	wire t3 = (phase_r == lce_pkg::PH3);
	wire t4 = (phase_r == lce_pkg::PH4);
	wire phase_six_tick = (phase_r == lce_pkg::PH6);
	wire busy = (step_r != lce_pkg::STP_IDLE);
	wire dl = busy & ~is_ic_r;
	wire ic = busy & is_ic_r;
	wire s1 = (step_r == lce_pkg::STP_S1);
	wire s2 = (step_r == lce_pkg::STP_S2);
	wire s3 = (step_r == lce_pkg::STP_S3);
	wire s4 = (step_r == lce_pkg::STP_S4);
	wire s5 = (step_r == lce_pkg::STP_S5);
	wire s6 = (step_r == lce_pkg::STP_S6);
	wire sx = (step_r == lce_pkg::STP_XFER);
	wire a_fg = a_r[lce_pkg::FG_BIT];
	wire char_ok = (char_r != lce_pkg::CR_CHAR);
	wire at_end = (col_r == lce_pkg::LAST_COL) & (row_r == lce_pkg::LAST_ROW);

	// command sources; a host start is a single-cycle write, keys are edges
	wire wr_ctrl = i_wr & (i_addr == lce_pkg::OFS_CTRL);
	wire wr_cur = i_wr & (i_addr == lce_pkg::OFS_CURSOR) & ~busy;
	wire host_dl = wr_ctrl & i_wdata[lce_pkg::CTRL_DL_BIT];
	wire start_dl = ~busy & ((dl_s2_r & ~dl_s3_r) | host_dl);
	wire start_ic = ~busy & ~start_dl & ic_s2_r & ~ic_s3_r;

	// cursor counter controls
	wire column_counter_clear = (s1 & dl & t2) | (sx & t2);
	wire cur_load = sx & t4;
	wire col_inc = t3 & ((s6 & dl & ~end_r) | (s5 & ic));
	wire col_carry = col_inc & (col_r == lce_pkg::LAST_COL);
	wire row_inc = (t3 & s3 & dl) | col_carry;
	wire row_dec = t3 & s4 & dl;
	wire cursor_counter_clock = column_counter_clear | cur_load | col_inc | row_inc | row_dec;

	always_comb begin
		col_nxt = col_r;
		row_nxt = row_r;
		if (column_counter_clear) begin
			col_nxt = '0;
			row_nxt = sx ? '0 : row_r;
		end else if (cur_load) begin
			col_nxt = ~ccol_r;
			row_nxt = ~crow_r;
		end else if (cursor_counter_clock) begin
			if (col_inc) begin
				col_nxt = col_carry ? '0 : col_r + 7'h01;
			end
			if (row_inc) begin
				row_nxt = row_r + 5'h01;
			end else if (row_dec) begin
				row_nxt = row_r - 5'h01;
			end
		end else if (wr_cur) begin
			col_nxt = i_wdata[lce_pkg::CUR_COL_LSB +: 7];
			row_nxt = i_wdata[lce_pkg::CUR_ROW_LSB +: 5];
		end
	end

	// memory commands, all on t0.6
	wire rr_go = phase_six_tick & ((s3 & dl) | (s2 & ic) | (s5 & ic));
	wire cw_dl = phase_six_tick & s4 & dl;
	wire cw_ic1 = phase_six_tick & s3 & ic & a_fg & char_ok;
	wire cw_ic2 = phase_six_tick & s6 & ic & a_fg;
	wire cw_go = cw_dl | cw_ic1 | cw_ic2;
	wire ab_copy = phase_six_tick & ((s4 & dl) | (s5 & ic));

	// B takes A on the same edge, so the dl write carries A directly
	assign cwd_nxt = cw_dl ? (last_r ? lce_pkg::BLANK_CHAR : a_r) :
	                 cw_ic1 ? char_r : b_r;

	// step sequencing; busy steps change only at the end of t0.6, the start from idle on any edge
	always_comb begin
		step_nxt = step_r;
		case (step_r)
			lce_pkg::STP_IDLE: begin
				if (start_dl | start_ic) begin
					step_nxt = lce_pkg::STP_S1;
				end
			end
			lce_pkg::STP_S1: step_nxt = lce_pkg::STP_S2;
			lce_pkg::STP_S2: step_nxt = lce_pkg::STP_S3;
			lce_pkg::STP_S3: begin
				step_nxt = (is_ic_r & ~a_fg) ? lce_pkg::STP_XFER : lce_pkg::STP_S4;
			end
			lce_pkg::STP_S4: begin
				step_nxt = (is_ic_r & end_r) ? lce_pkg::STP_XFER : lce_pkg::STP_S5;
			end
			lce_pkg::STP_S5: step_nxt = lce_pkg::STP_S6;
			lce_pkg::STP_S6: begin
				if (is_ic_r) begin
					step_nxt = a_fg ? lce_pkg::STP_S4 : lce_pkg::STP_XFER;
				end else begin
					step_nxt = end_r ? lce_pkg::STP_XFER : lce_pkg::STP_S3;
				end
			end
			lce_pkg::STP_XFER: step_nxt = lce_pkg::STP_IDLE;
			default: step_nxt = lce_pkg::STP_IDLE;
		endcase
	end

	// register read mux
	wire [31:0] cur_word = {19'h0, row_r, 1'b0, col_r};
	wire [31:0] st_word = {24'h0, 4'(step_r), is_ic_r, skip_r, last_r, busy};
	assign rdata_nxt = ~i_rd ? 32'h0 :
	                   (i_addr == lce_pkg::OFS_CURSOR) ? cur_word :
	                   (i_addr == lce_pkg::OFS_STATUS) ? st_word : 32'h0;

	// pin synchronisers; the second stage feeds logic, the third only the key edge detects
	always_ff @(posedge i_sys_clk) begin
		dl_s1_r  <= i_key_del_line;
		dl_s2_r  <= dl_s1_r;
		dl_s3_r  <= dl_s2_r;
		ic_s1_r  <= i_key_ins_char;
		ic_s2_r  <= ic_s1_r;
		ic_s3_r  <= ic_s2_r;
		chr_s1_r <= i_key_char;
		chr_s2_r <= chr_s1_r;
	end

	// phase counter holds at t0.1 while idle so a routine starts on a fresh cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			phase_r <= lce_pkg::PH1;
			step_r  <= lce_pkg::STP_IDLE;
		end else if (~busy) begin
			phase_r <= lce_pkg::PH1;
			step_r  <= step_nxt;
		end else if (phase_six_tick) begin
			phase_r <= lce_pkg::PH1;
			step_r  <= step_nxt;
		end else begin
			phase_r <= phase_r + 3'h1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			row_r   <= '0;
			col_r   <= '0;
			crow_r  <= '0;
			ccol_r  <= '0;
			is_ic_r <= 1'b0;
			char_r  <= '0;
		end else begin
			row_r <= row_nxt;
			col_r <= col_nxt;
			if (s2 & t1) begin
				crow_r <= ~row_r;
				ccol_r <= ~col_r;
			end
			if (start_dl | start_ic) begin
				is_ic_r <= start_ic;
				char_r  <= chr_s2_r;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			last_r <= 1'b0;
			end_r  <= 1'b0;
			xfer_r <= 1'b0;
			skip_r <= 1'b0;
		end else begin
			if (s1 & t1) begin
				last_r <= 1'b0;
			end else if (s3 & dl & t2 & (row_r == lce_pkg::LAST_ROW)) begin
				// only the toggle out of reset matters; holding keeps the whole bottom row blank
				last_r <= 1'b1;
			end
			if (t1) begin
				end_r <= at_end;
			end
			if (sx & t1) begin
				xfer_r <= 1'b1;
			end else if (~busy) begin
				xfer_r <= 1'b0;
			end
			if (s1 & ic & t1) begin
				skip_r <= 1'b1;
			end else if (~busy) begin
				skip_r <= 1'b0;
			end
		end
	end

	// A loads from memory the cycle after the read-restore pulse
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rr_r    <= 1'b0;
			rr_d_r  <= 1'b0;
			cw_r    <= 1'b0;
			cwd_r   <= '0;
			a_r     <= '0;
			b_r     <= '0;
			rdata_r <= '0;
		end else begin
			rr_r    <= rr_go;
			rr_d_r  <= rr_r;
			cw_r    <= cw_go;
			rdata_r <= rdata_nxt;
			if (cw_go) begin
				cwd_r <= cwd_nxt;
			end
			if (rr_d_r) begin
				a_r <= i_mem_rdata;
			end
			if (ab_copy) begin
				b_r <= a_r;
			end
		end
	end

	assign o_rdata        = rdata_r;
	assign o_mem_row      = row_r;
	assign o_mem_col      = col_r;
	assign o_rr_cmd       = rr_r;
	assign o_cw_cmd       = cw_r;
	assign o_cw_data      = cwd_r;
	assign o_skip_refresh = skip_r;
	assign o_busy         = busy;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	chk_col_clear_dl: assert property (
		s1 & dl & t2 |=> col_r == 7'h00 && row_r == $past(row_r))
		else $error("column not cleared in delete step one");
	chk_last_reset: assert property (
		s1 & t1 |=> !last_r ##5 step_r == lce_pkg::STP_S2)
		else $error("step one did not reset flag or advance");
	chk_coinc_save: assert property (
		s2 & t1 |=> ccol_r == ~$past(col_r) && crow_r == ~$past(row_r))
		else $error("cursor not saved complemented");
	chk_row_step_dl: assert property (
		s3 & dl & t3 |=> row_r == $past(row_r) + 5'h01)
		else $error("row not advanced in step three");
	chk_read_s3: assert property (
		s3 & dl & phase_six_tick |=> o_rr_cmd ##1 !o_rr_cmd)
		else $error("read-restore missing after step three");
	chk_blank_write: assert property (
		s4 & dl & phase_six_tick & last_r |=> o_cw_cmd && o_cw_data == lce_pkg::BLANK_CHAR)
		else $error("last line not written blank");
	chk_cursor_restore: assert property (
		sx & t4 |=> col_r == ~ccol_r && row_r == ~crow_r && xfer_r)
		else $error("cursor not restored from saved copy");
	chk_bg_stop: assert property (
		s3 & ic & phase_six_tick & !a_fg |=> step_r == lce_pkg::STP_XFER && !o_cw_cmd)
		else $error("background cell did not stop insert");
	chk_phase_order: assert property (
		busy & !phase_six_tick |=> phase_r == $past(phase_r) + 3'h1 && $stable(step_r))
		else $error("phase order or step change broken");
	chk_last_set: assert property (
		s3 & dl & t2 & (row_r == lce_pkg::LAST_ROW) |=> last_r)
		else $error("last-line flag not set on row 26");
	chk_row_back_dl: assert property (
		s4 & dl & t3 |=> row_r == $past(row_r) - 5'h01)
		else $error("row not stepped back in step four");
	chk_ab_copy_dl: assert property (
		s4 & dl & phase_six_tick |=> b_r == $past(a_r))
		else $error("A not copied into B in step four");
	chk_data_write: assert property (
		s4 & dl & phase_six_tick & !last_r |=> o_cw_cmd && o_cw_data == $past(a_r))
		else $error("moved character not written");
	chk_col_step_dl: assert property (
		s6 & dl & t3 & !end_r & (col_r != lce_pkg::LAST_COL) |=> col_r == $past(col_r) + 7'h01)
		else $error("column not advanced in step six");
	chk_col_carry_dl: assert property (
		s6 & dl & t3 & !end_r & (col_r == lce_pkg::LAST_COL) |=>
			col_r == 7'h00 && row_r == $past(row_r) + 5'h01)
		else $error("column carry did not advance row");
	chk_end_stop_dl: assert property (
		s6 & dl & phase_six_tick & end_r |=> step_r == lce_pkg::STP_XFER)
		else $error("delete did not stop at last position");
	chk_skip_set: assert property (
		s1 & ic & t1 |=> o_skip_refresh)
		else $error("refresh skip not set in insert");
	chk_char_write: assert property (
		s3 & ic & phase_six_tick & a_fg & char_ok |=> o_cw_cmd && o_cw_data == $past(char_r))
		else $error("typed character not written");
	chk_ins_end: assert property (
		s4 & ic & phase_six_tick & end_r |=> step_r == lce_pkg::STP_XFER)
		else $error("insert did not stop at last position");

endmodule : lce_sequencer

`default_nettype wire

//--- verification/lce_mem_model.sv
// character memory partner for the edit sequencer
// assumes one-clock command pulses; read data stands only in the cycle after o_rr_cmd
`default_nettype none
module lce_mem_model (
	input  wire logic       i_sys_clk,
	input  wire logic [4:0] i_row,
	input  wire logic [6:0] i_col,
	input  wire logic       i_rr,
	input  wire logic       i_cw,
	input  wire logic [7:0] i_cw_data,
	output logic [7:0]      o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:4095];
	logic [7:0] rd_r = 8'h00;
	assign o_rdata = rd_r;
	// outside its valid cycle the bus inverts every clock, so a sample one cycle late is caught
	always @(posedge i_sys_clk) begin
		if (i_cw)
			mem[{i_row, i_col}] <= i_cw_data;
		rd_r <= i_rr ? mem[{i_row, i_col}] : ~rd_r;
	end
endmodule : lce_mem_model
`default_nettype wire

//--- verification/tb_line_char_edit_sequencer.sv
// self-checking bench: host and key delete line, insert character, register port
// assumes the memory partner model; expected screen kept in a shadow array
`default_nettype none
module tb_line_char_edit_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LAST_POS = 1997;
	logic        clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, kdl = 1'b0, kic = 1'b0;
	logic [7:0]  addr = 8'h00, kchar = 8'h00, mrd, cwd, ch;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [4:0]  row;
	logic [6:0]  col;
	logic        rr, cw, skip, busy;
	logic [7:0]  exp_mem [0:4095];
	int          n_errors = 0, n_compared = 0;

	always #20 clk = ~clk;

	lce_sequencer u_dut (.i_sys_clk(clk), .i_reset(reset), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .i_key_del_line(kdl), .i_key_ins_char(kic), .i_key_char(kchar),
		.i_mem_rdata(mrd), .o_rdata(rdata), .o_mem_row(row), .o_mem_col(col), .o_rr_cmd(rr),
		.o_cw_cmd(cw), .o_cw_data(cwd), .o_skip_refresh(skip), .o_busy(busy));
	lce_mem_model u_mem (.i_sys_clk(clk), .i_row(row), .i_col(col), .i_rr(rr), .i_cw(cw),
		.i_cw_data(cwd), .o_rdata(mrd));

	task automatic tally_and_finish();
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : expect_eq

	function automatic logic [31:0] cur(input int r, input int c);
		return {19'h0, r[4:0], 1'b0, c[6:0]};
	endfunction : cur

	function automatic int idx(input int p);
		return (p / 74) * 128 + p % 74;
	endfunction : idx

	// all tasks start and end just after a rising edge
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// one idle edge so a following write never re-raises the strobe in the same step
		@(posedge clk);
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : bus_rd

	task automatic wait_done(input int lim);
		int i;
		for (i = 0; i < 12 && busy !== 1'b1; i++)
			@(posedge clk);
		expect_eq({31'h0, busy}, 32'h1, "busy after start");
		for (i = 0; i < lim && busy !== 1'b0; i++)
			@(posedge clk);
		if (busy !== 1'b0) begin
			expect_eq({31'h0, busy}, 32'h0, "routine hang");
			tally_and_finish();
		end
		@(posedge clk);
	endtask : wait_done

	task automatic fill();
		logic [31:0] v;
		for (int i = 0; i < 4096; i++) begin
			v = $urandom;
			u_mem.mem[i] = v[7:0];
			exp_mem[i] = v[7:0];
		end
	endtask : fill

	task automatic cmp_mem(input string what);
		int bad;
		bad = 0;
		for (int p = 0; p <= LAST_POS; p++)
			if (u_mem.mem[idx(p)] !== exp_mem[idx(p)])
				bad++;
		expect_eq(32'(bad), 32'h0, what);
	endtask : cmp_mem

	// rows from the cursor row roll up one, bottom row becomes blank
	function automatic void exp_delete(input int r);
		for (int p = r * 74; p <= LAST_POS; p++)
			exp_mem[idx(p)] = (p + 74 <= LAST_POS) ? exp_mem[idx(p + 74)] : 8'h00;
	endfunction : exp_delete

	// the last foreground cell before background is lost: its shift needs a foreground target
	function automatic void exp_insert(input int p0, input logic [7:0] c);
		logic [7:0] prev, tmp;
		if (exp_mem[idx(p0)][lce_pkg::FG_BIT] !== 1'b1)
			return;
		prev = exp_mem[idx(p0)];
		if (c !== lce_pkg::CR_CHAR)
			exp_mem[idx(p0)] = c;
		for (int p = p0 + 1; p <= LAST_POS && exp_mem[idx(p)][lce_pkg::FG_BIT] === 1'b1; p++) begin
			tmp = exp_mem[idx(p)];
			exp_mem[idx(p)] = prev;
			prev = tmp;
		end
	endfunction : exp_insert

	task automatic run_delete(input int r, input int c, input logic by_key);
		fill();
		exp_delete(r);
		bus_wr(lce_pkg::OFS_CURSOR, cur(r, c));
		if (by_key) begin
			kdl <= 1'b1;
			repeat (6) @(posedge clk);
			kdl <= 1'b0;
		end else begin
			bus_wr(lce_pkg::OFS_CTRL, 32'h1);
			bus_wr(lce_pkg::OFS_CURSOR, 32'h0);
			bus_rd(lce_pkg::OFS_STATUS, rv);
			expect_eq(rv & 32'h1, 32'h1, "status busy");
		end
		wait_done(30000);
		// step one clears the column before step two saves it, so delete returns to column 0
		expect_eq({19'h0, row, 1'b0, col}, cur(r, 0), "cursor after delete");
		bus_rd(lce_pkg::OFS_CURSOR, rv);
		expect_eq(rv, cur(r, 0), "cursor reg after delete");
		cmp_mem("screen after delete");
	endtask : run_delete

	task automatic run_insert(input int r, input int c, input int k, input logic [7:0] t);
		int p0;
		p0 = r * 74 + c;
		fill();
		for (int p = p0; p <= LAST_POS && p <= p0 + k; p++) begin
			u_mem.mem[idx(p)][lce_pkg::FG_BIT] = (p < p0 + k);
			exp_mem[idx(p)][lce_pkg::FG_BIT] = (p < p0 + k);
		end
		exp_insert(p0, t);
		bus_wr(lce_pkg::OFS_CURSOR, cur(r, c));
		kchar <= t;
		@(posedge clk);
		kic <= 1'b1;
		repeat (8) @(posedge clk);
		expect_eq({31'h0, skip}, 32'h1, "skip refresh in insert");
		kic <= 1'b0;
		wait_done(3000);
		expect_eq({31'h0, skip}, 32'h0, "skip refresh after insert");
		expect_eq({19'h0, row, 1'b0, col}, cur(r, c), "cursor after insert");
		cmp_mem("screen after insert");
	endtask : run_insert

	initial begin
		void'($urandom(32'hD9E6DDC9));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		expect_eq({16'h0, busy, rr, cw, skip, row, col}, 32'h0, "idle after reset");
		bus_wr(lce_pkg::OFS_CURSOR, cur(17, 73));
		bus_rd(lce_pkg::OFS_CURSOR, rv);
		expect_eq(rv, cur(17, 73), "cursor readback");
		bus_rd(8'h0C, rv);
		expect_eq(rv, 32'h0, "unmapped read");
		run_delete(20, $urandom_range(73), 1'b0);
		run_delete(24, 5, 1'b1);
		for (int n = 0; n < 3; n++) begin
			ch = 8'($urandom);
			if (ch === lce_pkg::CR_CHAR)
				ch = 8'h20;
			run_insert($urandom_range(25), $urandom_range(73), 1 + $urandom_range(9), ch);
		end
		run_insert(3, 10, 0, 8'h41);
		run_insert(26, 70, 4, 8'h42);
		run_insert(5, 73, 3, lce_pkg::CR_CHAR);
		tally_and_finish();
	end
endmodule : tb_line_char_edit_sequencer
`default_nettype wire
